// ==== verilog/umul_core.sv ====
// The placing of the registers and the Wishbone slave port were decided locally.
`timescale 1ns/100ps
// multiply datapath with operand selection and a classic wishbone register slave
module umul_core (
  // clock and reset
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_rst_b,
  // wishbone slave
  input  wire logic                       i_wb_cyc,
  input  wire logic                       i_wb_stb,
  input  wire logic                       i_wb_we,
  input  wire logic [umul_pkg::ADR_W-1:0] i_wb_adr,
  input  wire logic [umul_pkg::SEL_W-1:0] i_wb_sel,
  input  wire logic [umul_pkg::DAT_W-1:0] i_wb_dat,
  output logic      [umul_pkg::DAT_W-1:0] o_wb_dat,
  output logic                            o_wb_ack,
  // datapath view
  output logic      [7:0]                 o_product_high_byte,
  output logic      [7:0]                 o_product_low_byte,
  output logic                            o_busy
);
  import umul_pkg::*;

  // all block state except the data memory
  typedef struct packed {
    umul_phase_t  phase;
    logic         ext_set_en;
    logic [7:0]   acc;
    logic [3:0]   bank_select_register;
    logic [11:0]  index_base;
    logic [15:0]  instr;
    logic         is_lit;
    logic         is_mem;
    logic [11:0]  op_addr;
    logic [7:0]   operand;
    logic [15:0]  product;
    logic [7:0]   product_high_byte;
    logic [7:0]   product_low_byte;
    logic [4:0]   flags;
    logic         unsupported;
    logic [11:0]  mem_addr;
    logic         ack;
    logic [31:0]  rdata;
  } umul_state_t;

  umul_state_t st_reg;
  umul_state_t st_next;

  // general purpose data memory
  logic [7:0]  general_purpose_memory [MEM_DEPTH];

  logic        mem_we;
  logic [11:0] mem_wa;
  logic [7:0]  mem_wd;
  logic [15:0] mult_p;
  logic [11:0] resolved_addr;
  logic [31:0] wmask;
  logic        bus_req;
  logic        bus_wr;
  logic        bus_rd;

  // byte-lane write mask from select
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = i_wb_sel[b] ? 8'hFF : 8'h00;
    end
  end

  // a new request is taken once; ack drops the cycle after it was given
  assign bus_req = i_wb_cyc && i_wb_stb && !st_reg.ack;
  assign bus_wr  = bus_req && i_wb_we;
  assign bus_rd  = bus_req && !i_wb_we;

  // operand address from the latched instruction's access-select and field
  always_comb begin
    logic [7:0] f;
    f = st_reg.instr[7:0];
    if (st_reg.instr[8]) begin
      resolved_addr = {st_reg.bank_select_register, f};                   // [RULE8]
    end else if (st_reg.ext_set_en && (f <= IDX_LIMIT)) begin
      resolved_addr = st_reg.index_base + {4'h0, f};                     // [RULE9]
    end else if (f < ACCESS_SPLIT) begin
      resolved_addr = {ACCESS_LO_BANK, f};                                // [RULE7]
    end else begin
      resolved_addr = {ACCESS_HI_BANK, f};                                // [RULE7]
    end
  end

  // multiplier: accumulator times latched operand
  umul_mult8 u_mult (
    .i_a (st_reg.acc),
    .i_b (st_reg.operand),
    .o_p (mult_p)
  );

  // next-state logic: bus slave plus instruction phases
  always_comb begin
    st_next = st_reg;
    mem_we  = 1'b0;
    mem_wa  = st_reg.mem_addr;
    mem_wd  = 8'h00;

    // ack is a one-cycle answer to each new request
    st_next.ack = bus_req;

    // instruction phases, one clock each
    case (st_reg.phase)
      UMUL_IDLE: begin
        st_next.phase = UMUL_IDLE;
      end
      UMUL_Q1: begin
        // decode: memory form and literal form
        st_next.is_mem = (st_reg.instr[15:9] == OPC_MEM_MUL);            // [RULE6]
        st_next.is_lit = (st_reg.instr[15:8] == OPC_LIT_MUL);            // [RULE10]
        st_next.op_addr = resolved_addr;
        if ((st_reg.instr[15:9] != OPC_MEM_MUL) &&
            (st_reg.instr[15:8] != OPC_LIT_MUL)) begin
          st_next.unsupported = 1'b1;
          st_next.phase       = UMUL_IDLE;
        end else begin
          st_next.phase = UMUL_Q2;                                         // [RULE11]
        end
      end
      UMUL_Q2: begin
        // read operand: memory byte or immediate, memory is only read
        if (st_reg.is_mem) begin
          st_next.operand = general_purpose_memory[st_reg.op_addr];      // [RULE1]
        end else begin
          st_next.operand = st_reg.instr[7:0];                            // [RULE10]
        end
        st_next.phase = UMUL_Q3;                                           // [RULE11]
      end
      UMUL_Q3: begin
        // process: unsigned product, no zero test and no flag update
        st_next.product = mult_p;                                          // [RULE5]
        st_next.phase   = UMUL_Q4;                                         // [RULE11]
      end
      UMUL_Q4: begin
        // write only the product pair; acc and flags untouched
        st_next.product_high_byte = st_reg.product[15:8];                // [RULE2]
        st_next.product_low_byte  = st_reg.product[7:0];                 // [RULE2]
        st_next.phase             = UMUL_IDLE;                            // [RULE3]
      end
      default: begin
        st_next.phase = UMUL_IDLE;
      end
    endcase

    // register writes; flags field is written only by software
    if (bus_wr) begin
      if (i_wb_adr == OFS_CTRL) begin
        if (i_wb_sel[0]) begin
          st_next.ext_set_en = i_wb_dat[CTRL_EXT_BIT];
        end
      end else if (i_wb_adr == OFS_ACC) begin
        if (i_wb_sel[0]) begin
          st_next.acc = i_wb_dat[7:0];
        end
      end else if (i_wb_adr == OFS_BANK) begin
        if (i_wb_sel[0]) begin
          st_next.bank_select_register = i_wb_dat[BANK_W-1:0];
        end
      end else if (i_wb_adr == OFS_INDEX) begin
        st_next.index_base = (st_reg.index_base & ~wmask[11:0]) |
                             (i_wb_dat[11:0] & wmask[11:0]);
      end else if (i_wb_adr == OFS_INSTR) begin
        // issue only while idle and with both opcode bytes written
        if ((st_reg.phase == UMUL_IDLE) && (i_wb_sel[1:0] == 2'b11)) begin
          st_next.instr       = i_wb_dat[15:0];
          st_next.phase       = UMUL_Q1;                                   // [RULE11]
          st_next.unsupported = 1'b0;
        end
      end else if (i_wb_adr == OFS_STATUS) begin
        if (i_wb_sel[0]) begin
          st_next.flags = i_wb_dat[STAT_FLAGS_LSB +: FLAG_W];              // [RULE4]
        end
      end else if (i_wb_adr == OFS_MEM_ADDR) begin
        st_next.mem_addr = (st_reg.mem_addr & ~wmask[11:0]) |
                           (i_wb_dat[11:0] & wmask[11:0]);
      end else if (i_wb_adr == OFS_MEM_DATA) begin
        if (i_wb_sel[0]) begin
          mem_we = 1'b1;
          mem_wa = st_reg.mem_addr;
          mem_wd = i_wb_dat[7:0];
        end
      end
    end

    // register reads; unmapped offsets answer zero
    if (bus_rd) begin
      st_next.rdata = 32'h0000_0000;
      if (i_wb_adr == OFS_CTRL) begin
        st_next.rdata[CTRL_EXT_BIT] = st_reg.ext_set_en;
      end else if (i_wb_adr == OFS_ACC) begin
        st_next.rdata[7:0] = st_reg.acc;
      end else if (i_wb_adr == OFS_BANK) begin
        st_next.rdata[BANK_W-1:0] = st_reg.bank_select_register;
      end else if (i_wb_adr == OFS_INDEX) begin
        st_next.rdata[11:0] = st_reg.index_base;
      end else if (i_wb_adr == OFS_INSTR) begin
        st_next.rdata[15:0] = st_reg.instr;
      end else if (i_wb_adr == OFS_PRODUCT) begin
        st_next.rdata[15:0] = {st_reg.product_high_byte, st_reg.product_low_byte};
      end else if (i_wb_adr == OFS_STATUS) begin
        st_next.rdata[STAT_FLAGS_LSB +: FLAG_W] = st_reg.flags;
        st_next.rdata[STAT_BUSY_BIT]           = (st_reg.phase != UMUL_IDLE);
        st_next.rdata[STAT_UNSUP_BIT]          = st_reg.unsupported;
      end else if (i_wb_adr == OFS_MEM_ADDR) begin
        st_next.rdata[11:0] = st_reg.mem_addr;
      end else if (i_wb_adr == OFS_MEM_DATA) begin
        st_next.rdata[7:0] = general_purpose_memory[st_reg.mem_addr];
      end
    end
  end

  // state register with synchronous active-low reset
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      st_reg.phase                <= UMUL_IDLE;
      st_reg.ext_set_en           <= 1'b0;
      st_reg.acc                  <= RST_ACC;
      st_reg.bank_select_register <= RST_BANK;
      st_reg.index_base           <= RST_INDEX;
      st_reg.instr                <= RST_INSTR;
      st_reg.is_lit               <= 1'b0;
      st_reg.is_mem               <= 1'b0;
      st_reg.op_addr              <= 12'h000;
      st_reg.operand              <= 8'h00;
      st_reg.product              <= 16'h0000;
      st_reg.product_high_byte    <= 8'h00;
      st_reg.product_low_byte     <= 8'h00;
      st_reg.flags                <= RST_FLAGS;
      st_reg.unsupported          <= 1'b0;
      st_reg.mem_addr             <= 12'h000;
      st_reg.ack                  <= 1'b0;
      st_reg.rdata                <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
    end
  end

  // data memory: written only by the bus, never by a multiply
  always_ff @(posedge i_clk_sys) begin
    if (mem_we) begin
      general_purpose_memory[mem_wa] <= mem_wd;                           // [RULE3]
    end
  end

  // outputs
  assign o_wb_ack            = st_reg.ack;
  assign o_wb_dat            = st_reg.rdata;
  assign o_product_high_byte = st_reg.product_high_byte;
  assign o_product_low_byte  = st_reg.product_low_byte;
  assign o_busy              = (st_reg.phase != UMUL_IDLE);

endmodule : umul_core

// ==== verilog/umul_pkg.sv ====
// Summary of operation
// [RULE1] memory-operand multiply forms the unsigned product of accumulator and addressed byte
// [RULE2] 16-bit product goes to the pair: upper byte high, lower byte low
// [RULE3] accumulator and source memory byte stay unchanged; only the pair is written
// [RULE4] no status flag (negative, overflow, carry, digit carry, zero) is updated
// [RULE5] a zero product is not detected or flagged
// [RULE6] memory-operand opcode is 0000 001, access-select bit, 8-bit address field
// [RULE7] access-select 0 takes the operand from the shared direct bank
// [RULE8] access-select 1 uses the bank select register to locate the operand
// [RULE9] extended set on, access-select 0, address 95 or below: indexed literal offset
// [RULE10] literal multiply: opcode 0000 1101, accumulator times immediate, same write
// [RULE11] one word, one instruction cycle: decode, read, multiply, write product
package umul_pkg;

  // bus geometry
  localparam int unsigned ADR_W  = 8;
  localparam int unsigned DAT_W  = 32;
  localparam int unsigned SEL_W  = 4;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_ACC      = 8'h04;
  localparam logic [7:0] OFS_BANK     = 8'h08;
  localparam logic [7:0] OFS_INDEX    = 8'h0C;
  localparam logic [7:0] OFS_INSTR    = 8'h10;
  localparam logic [7:0] OFS_PRODUCT  = 8'h14;
  localparam logic [7:0] OFS_STATUS   = 8'h18;
  localparam logic [7:0] OFS_MEM_ADDR = 8'h1C;
  localparam logic [7:0] OFS_MEM_DATA = 8'h20;

  // field positions
  localparam int unsigned CTRL_EXT_BIT    = 0;
  localparam int unsigned STAT_FLAGS_LSB  = 0;
  localparam int unsigned STAT_BUSY_BIT   = 8;
  localparam int unsigned STAT_UNSUP_BIT  = 9;

  // widths
  localparam int unsigned MEM_AW  = 12;
  localparam int unsigned MEM_DEPTH = 4096;
  localparam int unsigned BANK_W  = 4;
  localparam int unsigned FLAG_W  = 5;

  // opcode fields
  localparam logic [6:0] OPC_MEM_MUL = 7'h01;   // upper bits 0000 001
  localparam logic [7:0] OPC_LIT_MUL = 8'h0D;   // upper byte 0000 1101

  // operand address resolution
  localparam logic [7:0] IDX_LIMIT    = 8'h5F;  // 95: highest indexed offset
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;  // low half of shared bank below this
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;

  // reset values
  localparam logic [7:0]  RST_ACC   = 8'h00;
  localparam logic [3:0]  RST_BANK  = 4'h0;
  localparam logic [11:0] RST_INDEX = 12'h000;
  localparam logic [15:0] RST_INSTR = 16'h0000;
  localparam logic [4:0]  RST_FLAGS = 5'h00;

  // instruction phase sequence
  typedef enum logic [2:0] {
    UMUL_IDLE,
    UMUL_Q1,
    UMUL_Q2,
    UMUL_Q3,
    UMUL_Q4
  } umul_phase_t;

endpackage : umul_pkg

// ==== verilog/umul_mult8.sv ====
`timescale 1ns/100ps
// combinational 8x8 unsigned shift-and-add multiplier
module umul_mult8 (
  // operands
  input  wire logic [7:0]  i_a,
  input  wire logic [7:0]  i_b,
  // result
  output logic      [15:0] o_p
);

  logic [15:0] pp [8];

  // one partial product per multiplier bit, operands treated as unsigned
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pp
      assign pp[gi] = i_b[gi] ? ({8'h00, i_a} << gi) : 16'h0000;  // [RULE1]
    end
  endgenerate

  // sum of partial products; 8x8 never exceeds 16 bits
  always_comb begin
    logic [15:0] acc;
    acc = 16'h0000;
    for (int k = 0; k < 8; k++) begin
      acc = acc + pp[k];
    end
    o_p = acc;
  end

endmodule : umul_mult8

// ==== test/umul_core_chk.sv ====
`timescale 1ns/100ps
// protocol and datapath checker for the multiply block
module umul_core_chk
  import umul_pkg::*;
(
  // clock and reset
  input wire logic                       i_clk_sys,
  input wire logic                       i_rst_b,
  // wishbone slave
  input wire logic                       i_wb_cyc,
  input wire logic                       i_wb_stb,
  input wire logic                       i_wb_we,
  input wire logic [umul_pkg::ADR_W-1:0] i_wb_adr,
  input wire logic [umul_pkg::SEL_W-1:0] i_wb_sel,
  input wire logic [umul_pkg::DAT_W-1:0] i_wb_dat,
  input wire logic [umul_pkg::DAT_W-1:0] o_wb_dat,
  input wire logic                       o_wb_ack,
  // datapath view
  input wire logic [7:0]                 o_product_high_byte,
  input wire logic [7:0]                 o_product_low_byte,
  input wire logic                       o_busy
);
  logic [4:0] flags_reg;
  wire logic  tk = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire logic  rd = tk & ~i_wb_we;
  wire logic  issue = tk & i_wb_we & (i_wb_adr == OFS_INSTR) & (&i_wb_sel[1:0]) & ~o_busy;
  wire logic  ok_op = (i_wb_dat[15:9] == OPC_MEM_MUL) | (i_wb_dat[15:8] == OPC_LIT_MUL);
  wire logic  [15:0] prod = {o_product_high_byte, o_product_low_byte};
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  // mirror of the software flag register; a multiply must never move it
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) flags_reg <= '0;
    else if (tk && i_wb_we && i_wb_adr == OFS_STATUS && i_wb_sel[0]) flags_reg <= i_wb_dat[4:0];
  end
  ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
  ack_resp_a: assert property (tk |=> o_wb_ack) else $error("request not acked next cycle");
  issue_busy_a: assert property (issue && ok_op |=> o_busy [*4] ##1 !o_busy)
    else $error("multiply not four busy cycles");
  bad_op_a: assert property (issue && !ok_op |=> o_busy ##1 !o_busy)
    else $error("bad opcode not dropped after decode");
  prod_hold_a: assert property ($changed(prod) |-> $fell(o_busy))
    else $error("product moved outside a write phase");
  // read data is captured at the taking edge, so compare with the pair seen there
  prod_rd_a: assert property (rd && i_wb_adr == OFS_PRODUCT |=> o_wb_dat == {16'h0000, $past(prod)})
    else $error("product register does not match pins");
  flags_kept_a: assert property (rd && i_wb_adr == OFS_STATUS |=> o_wb_dat[4:0] == flags_reg)
    else $error("status flags changed");
  unmap_rd_a: assert property (rd && i_wb_adr > OFS_MEM_DATA |=> o_wb_dat == '0)
    else $error("unmapped read not zero");
  // main scenarios
  cover property (issue && ok_op);
  cover property (issue && !ok_op);
  cover property (rd && i_wb_adr == OFS_STATUS);
endmodule : umul_core_chk

bind umul_core umul_core_chk u_chk (
  .i_clk_sys, .i_rst_b, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat,
  .o_wb_dat, .o_wb_ack, .o_product_high_byte, .o_product_low_byte, .o_busy
);

// ==== test/umul_core_tb.sv ====
`timescale 1ns/100ps
// self-checking bench for the multiply block
module umul_core_tb;
  import umul_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hF;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  wire  [31:0] dat_o;
  wire         ack;
  wire         busy;
  wire  [7:0]  ph;
  wire  [7:0]  pl;
  int          n_mismatch = 0;
  int          total_checks = 0;
  umul_core u_dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(dat_o),
    .o_wb_ack(ack), .o_product_high_byte(ph), .o_product_low_byte(pl), .o_busy(busy));
  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one classic wishbone cycle; read data taken at the ack edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (k >= 20) n_mismatch++;
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic mw(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, OFS_MEM_ADDR, {20'h0_0000, a});
    bus(1'b1, OFS_MEM_DATA, {24'h00_0000, d});
  endtask : mw
  // issue, count busy cycles, read the pair back
  task automatic mul(input logic [15:0] ins, input logic [15:0] exp);
    int k;
    bus(1'b1, OFS_INSTR, {16'h0000, ins});
    k = 0;
    while (busy === 1'b1 && k < 20) begin
      @(posedge clk);
      k++;
    end
    chk(k, 4);
    chk({ph, pl}, exp);
    bus(1'b0, OFS_PRODUCT, 32'h0000_0000);
    chk(rdat, {16'h0000, exp});
  endtask : mul
  task automatic t_lit;
    bus(1'b1, OFS_STATUS, 32'h0000_0015);
    bus(1'b1, OFS_ACC, 32'h0000_00E2);
    mul(16'h0DC4, 16'hAD08);
    bus(1'b1, OFS_ACC, 32'h0000_00FF);
    mul(16'h0DFF, 16'hFE01);
    mul(16'h0D00, 16'h0000);
    bus(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(rdat, 32'h0000_0015);
    bus(1'b0, OFS_ACC, 32'h0000_0000);
    chk(rdat, 32'h0000_00FF);
  endtask : t_lit
  task automatic t_mem;
    bus(1'b1, OFS_BANK, 32'h0000_0003);
    mw(12'h3B5, 8'hB5);
    mw(12'hFB5, 8'h22);
    mw(12'h035, 8'h07);
    bus(1'b1, OFS_ACC, 32'h0000_00C4);
    mul(16'h03B5, 16'h8A94);
    mul(16'h02B5, 16'h1A08);
    mul(16'h0235, 16'h055C);
    bus(1'b1, OFS_MEM_ADDR, 32'h0000_03B5);
    bus(1'b0, OFS_MEM_DATA, 32'h0000_0000);
    chk(rdat, 32'h0000_00B5);
  endtask : t_mem
  task automatic t_ext;
    bus(1'b1, OFS_CTRL, 32'h0000_0001);
    bus(1'b1, OFS_INDEX, 32'h0000_0200);
    mw(12'h25F, 8'h03);
    mw(12'h060, 8'h05);
    mul(16'h025F, 16'h024C);
    mul(16'h0260, 16'h03D4);
    mul(16'h03B5, 16'h8A94);
  endtask : t_ext
  // opcodes outside both encodings leave the pair alone
  task automatic t_bad;
    bus(1'b1, OFS_INSTR, 32'h0000_0400);
    repeat (4) @(posedge clk);
    bus(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(rdat[9], 1'b1);
    bus(1'b1, OFS_INSTR, 32'h0000_0EC4);
    repeat (4) @(posedge clk);
    bus(1'b0, OFS_PRODUCT, 32'h0000_0000);
    chk(rdat, 32'h0000_8A94);
    bus(1'b0, 8'h40, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
  endtask : t_bad
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    bus(1'b0, OFS_PRODUCT, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    t_lit;
    t_mem;
    t_ext;
    t_bad;
    conclude;
  end
  // watchdog well past the few hundred cycles the tests need
  initial begin
    #50000;
    n_mismatch++;
    conclude;
  end
endmodule : umul_core_tb
